// ### hw/tsr_pkg.sv
// Register map, field layout and carrier types of the temperature monitor register bank
package tsr_pkg;
  localparam int DW = 8;
  // Read addresses
  localparam logic [7:0] RA_LOCAL_TEMP = 8'h00;
  localparam logic [7:0] RA_BANK_TEMP_HI = 8'h01;
  localparam logic [7:0] RA_STATUS_ONE = 8'h02;
  localparam logic [7:0] RA_CONFIG_ONE = 8'h03;
  localparam logic [7:0] RA_RATE = 8'h04;
  localparam logic [7:0] RA_LOCAL_HIGH = 8'h05;
  localparam logic [7:0] RA_LOCAL_LOW = 8'h06;
  localparam logic [7:0] RA_BANK_HIGH_HI = 8'h07;
  localparam logic [7:0] RA_BANK_LOW_HI = 8'h08;
  // Write addresses that differ from the read ones
  localparam logic [7:0] WA_CONFIG_ONE = 8'h09;
  localparam logic [7:0] WA_RATE = 8'h0a;
  localparam logic [7:0] WA_LOCAL_HIGH = 8'h0b;
  localparam logic [7:0] WA_LOCAL_LOW = 8'h0c;
  localparam logic [7:0] WA_BANK_HIGH_HI = 8'h0d;
  localparam logic [7:0] WA_BANK_LOW_HI = 8'h0e;
  localparam logic [7:0] WA_SINGLE_CONV = 8'h0f;
  // Same read and write address; the RA_ entries here are read-only
  localparam logic [7:0] RA_BANK_TEMP_LO = 8'h10;
  localparam logic [7:0] A_BANK_OFS_HI = 8'h11;
  localparam logic [7:0] A_BANK_OFS_LO = 8'h12;
  localparam logic [7:0] A_BANK_HIGH_LO = 8'h13;
  localparam logic [7:0] A_BANK_LOW_LO = 8'h14;
  localparam logic [7:0] A_BANK_OVT = 8'h19;
  localparam logic [7:0] A_LOCAL_OVT = 8'h20;
  localparam logic [7:0] A_OVT_HYST = 8'h21;
  localparam logic [7:0] A_ALARM_CTRL = 8'h22;
  localparam logic [7:0] RA_STATUS_TWO = 8'h23;
  localparam logic [7:0] A_CONFIG_TWO = 8'h24;
  localparam logic [7:0] RA_R2_TEMP_HI = 8'h30;
  localparam logic [7:0] A_R2_HIGH_HI = 8'h31;
  localparam logic [7:0] A_R2_LOW_HI = 8'h32;
  localparam logic [7:0] RA_R2_TEMP_LO = 8'h33;
  localparam logic [7:0] A_R2_OFS_HI = 8'h34;
  localparam logic [7:0] A_R2_OFS_LO = 8'h35;
  localparam logic [7:0] A_R2_HIGH_LO = 8'h36;
  localparam logic [7:0] A_R2_LOW_LO = 8'h37;
  localparam logic [7:0] A_R2_OVT = 8'h39;
  localparam logic [7:0] RA_PART_ID = 8'h3d;
  localparam logic [7:0] RA_MAKER_ID = 8'h3e;
  // Reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_RATE = 8'h07;
  localparam logic [7:0] RST_LIMIT = 8'h55;
  localparam logic [7:0] RST_HYST = 8'h0a;
  localparam logic [7:0] RST_ALARM_CTRL = 8'h01;
  // Fields
  localparam int CFG_BANK_BIT = 3;
  localparam int AC_SCL_TO_BIT = 7;
  localparam int AC_SDA_TO_BIT = 6;
  localparam int AC_MASK_LOCAL_BIT = 5;
  localparam int AC_RES_BIT = 4;
  localparam int AC_CNT_MSB = 3;
  localparam int AC_CNT_LSB = 1;
  localparam logic [7:0] OFS_LO_MASK = 8'hc0;
  localparam int OFS_W = 10;
  localparam int FRAC_W = 2;
  localparam int TEMP_W = 10;
  localparam logic [2:0] CNT_ONE = 3'h0;
  localparam logic [2:0] CNT_TWO = 3'h1;
  localparam logic [2:0] CNT_THREE = 3'h3;
  localparam logic [2:0] CNT_FOUR = 3'h7;
  localparam logic [2:0] THR_ONE = 3'h1;
  localparam logic [2:0] THR_TWO = 3'h2;
  localparam logic [2:0] THR_THREE = 3'h3;
  localparam logic [2:0] THR_FOUR = 3'h4;

  // One serial-engine byte event, already in link clock domain
  typedef struct packed {
    logic first;
    logic [7:0] data;
  } tsr_wbyte_s;

  // Raw remote measurement plus its channel
  typedef struct packed {
    logic chan2;
    logic [TEMP_W-1:0] raw;
  } tsr_meas_s;
endpackage

// ### hw/tsr_regs.sv
// Register bank of the three-channel temperature monitor with link-side pointer and crossings
`timescale 1ns/1ps
module tsr_regs #(
  parameter logic [7:0] PART_ID = 8'h5a,  // Arbitrary value
  parameter logic [7:0] MAKER_ID = 8'ha5  // Arbitrary value
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic link_clk,
  input wire logic link_rst_n,
  input wire logic wr_byte_valid,
  input wire tsr_pkg::tsr_wbyte_s wr_byte,
  input wire logic rd_req,
  output logic [7:0] rd_data,
  input wire logic standby,
  input wire logic meas_valid,
  input wire tsr_pkg::tsr_meas_s meas,
  input wire logic [7:0] local_temp,
  input wire logic [7:0] status_one_in,
  input wire logic [7:0] status_two_in,
  output logic single_conv_start,
  output logic [7:0] adj_temp_hi,
  output logic [7:0] adj_temp_lo,
  output logic adj_valid,
  output logic adj_chan2,
  output logic [2:0] alarm_threshold,
  output logic scl_timeout_en,
  output logic sda_timeout_en,
  output logic mask_local,
  output logic [7:0] config_one,
  output logic [7:0] rate_sel
);
  // Link side: pointer and write request captured on the link clock
  logic [7:0] ptr_reg;
  logic [7:0] lw_addr_reg;
  logic [7:0] lw_data_reg;
  logic lw_tog_reg;
  logic ptr_tog_reg;

  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      ptr_reg <= tsr_pkg::RST_ZERO;
      ptr_tog_reg <= 1'b0;
    end else if (wr_byte_valid && wr_byte.first) begin
      ptr_reg <= wr_byte.data;
      ptr_tog_reg <= ~ptr_tog_reg;
    end
  end

  // Address and data held stable until the toggle has crossed
  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      lw_addr_reg <= tsr_pkg::RST_ZERO;
      lw_data_reg <= tsr_pkg::RST_ZERO;
      lw_tog_reg <= 1'b0;
    end else if (wr_byte_valid && !wr_byte.first) begin
      lw_addr_reg <= ptr_reg;
      lw_data_reg <= wr_byte.data;
      lw_tog_reg <= ~lw_tog_reg;
    end
  end

  // Toggle crossing into system clock, three stages
  // Both resets must be released together, or a stale toggle reads as a write
  logic [2:0] tog_sync_reg;
  logic tog_seen_reg;
  logic wr_pulse;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tog_sync_reg <= 3'h0;
      tog_seen_reg <= 1'b0;
    end else begin
      tog_sync_reg <= {tog_sync_reg[1:0], lw_tog_reg};
      if (tog_sync_reg[1] == tog_sync_reg[2]) begin
        tog_seen_reg <= tog_sync_reg[2];
      end
    end
  end

  assign wr_pulse = (tog_sync_reg[1] == tog_sync_reg[2]) && (tog_sync_reg[2] != tog_seen_reg);
  // Stable by now: source holds them until the next toggle
  assign wr_addr = lw_addr_reg;
  assign wr_data = lw_data_reg;

  // Pointer crossing for reads: its own toggle, so no half-changed word is taken
  // Word is held on the link side until the next pointer byte arrives
  logic [2:0] ptr_sync_reg;
  logic ptr_seen_reg;
  logic ptr_pulse;
  logic [7:0] rd_ptr_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ptr_sync_reg <= 3'h0;
      ptr_seen_reg <= 1'b0;
    end else begin
      ptr_sync_reg <= {ptr_sync_reg[1:0], ptr_tog_reg};
      if (ptr_sync_reg[1] == ptr_sync_reg[2]) begin
        ptr_seen_reg <= ptr_sync_reg[2];
      end
    end
  end

  assign ptr_pulse = (ptr_sync_reg[1] == ptr_sync_reg[2]) && (ptr_sync_reg[2] != ptr_seen_reg);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_ptr_reg <= tsr_pkg::RST_ZERO;
    end else if (ptr_pulse) begin
      rd_ptr_reg <= ptr_reg;
    end
  end

  // Register storage
  logic [7:0] cfg1_reg, rate_reg, lhi_reg, llo_reg, ovt_l_reg, hyst_reg, actl_reg, cfg2_reg;
  logic [7:0] r1_hihi_reg, r1_lohi_reg, r1_hilo_reg, r1_lolo_reg, r1_ovt_reg;
  logic [7:0] r2_hihi_reg, r2_lohi_reg, r2_hilo_reg, r2_lolo_reg, r2_ovt_reg;
  logic [7:0] r1_ofs_hi_reg, r1_ofs_lo_reg, r2_ofs_hi_reg, r2_ofs_lo_reg;
  logic bank2;

  // Bank bit steers the shared offset, limit and value locations
  assign bank2 = cfg1_reg[tsr_pkg::CFG_BANK_BIT];

  function automatic logic wr_at(input logic [7:0] a, input logic [7:0] target);
    wr_at = wr_pulse && (a == target);
  endfunction

  // Banked write lands on remote 1 or remote 2 copy
  function automatic logic wr_bank(input logic [7:0] a, input logic [7:0] target,
                                   input logic want2, input logic b2);
    wr_bank = wr_pulse && (a == target) && (b2 == want2);
  endfunction

  // Configuration and local limits: distinct write addresses except local OVT, hysteresis and config two
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfg1_reg <= tsr_pkg::RST_ZERO;
      rate_reg <= tsr_pkg::RST_RATE;
      lhi_reg <= tsr_pkg::RST_LIMIT;
      llo_reg <= tsr_pkg::RST_ZERO;
      ovt_l_reg <= tsr_pkg::RST_LIMIT;
      hyst_reg <= tsr_pkg::RST_HYST;
      cfg2_reg <= tsr_pkg::RST_ZERO;
    end else begin
      if (wr_at(wr_addr, tsr_pkg::WA_CONFIG_ONE)) cfg1_reg <= wr_data;
      if (wr_at(wr_addr, tsr_pkg::WA_RATE)) rate_reg <= wr_data;
      if (wr_at(wr_addr, tsr_pkg::WA_LOCAL_HIGH)) lhi_reg <= wr_data;
      if (wr_at(wr_addr, tsr_pkg::WA_LOCAL_LOW)) llo_reg <= wr_data;
      if (wr_at(wr_addr, tsr_pkg::A_LOCAL_OVT)) ovt_l_reg <= wr_data;
      if (wr_at(wr_addr, tsr_pkg::A_OVT_HYST)) hyst_reg <= wr_data;
      if (wr_at(wr_addr, tsr_pkg::A_CONFIG_TWO)) cfg2_reg <= wr_data;
    end
  end

  // Alarm count and bus control; reserved bit never stored
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      actl_reg <= tsr_pkg::RST_ALARM_CTRL;
    end else if (wr_at(wr_addr, tsr_pkg::A_ALARM_CTRL)) begin
      actl_reg <= wr_data;
      actl_reg[tsr_pkg::AC_RES_BIT] <= 1'b0;
    end
  end

  // Remote limits: banked aliases plus direct second-remote addresses
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r1_hihi_reg <= tsr_pkg::RST_LIMIT;
      r1_lohi_reg <= tsr_pkg::RST_ZERO;
      r1_hilo_reg <= tsr_pkg::RST_ZERO;
      r1_lolo_reg <= tsr_pkg::RST_ZERO;
      r1_ovt_reg <= tsr_pkg::RST_LIMIT;
      r2_hihi_reg <= tsr_pkg::RST_LIMIT;
      r2_lohi_reg <= tsr_pkg::RST_ZERO;
      r2_hilo_reg <= tsr_pkg::RST_ZERO;
      r2_lolo_reg <= tsr_pkg::RST_ZERO;
      r2_ovt_reg <= tsr_pkg::RST_LIMIT;
    end else begin
      if (wr_bank(wr_addr, tsr_pkg::WA_BANK_HIGH_HI, 1'b0, bank2)) r1_hihi_reg <= wr_data;
      if (wr_bank(wr_addr, tsr_pkg::WA_BANK_LOW_HI, 1'b0, bank2)) r1_lohi_reg <= wr_data;
      if (wr_bank(wr_addr, tsr_pkg::A_BANK_HIGH_LO, 1'b0, bank2)) r1_hilo_reg <= wr_data;
      if (wr_bank(wr_addr, tsr_pkg::A_BANK_LOW_LO, 1'b0, bank2)) r1_lolo_reg <= wr_data;
      if (wr_bank(wr_addr, tsr_pkg::A_BANK_OVT, 1'b0, bank2)) r1_ovt_reg <= wr_data;
      if (wr_bank(wr_addr, tsr_pkg::WA_BANK_HIGH_HI, 1'b1, bank2) ||
          wr_at(wr_addr, tsr_pkg::A_R2_HIGH_HI)) r2_hihi_reg <= wr_data;
      if (wr_bank(wr_addr, tsr_pkg::WA_BANK_LOW_HI, 1'b1, bank2) ||
          wr_at(wr_addr, tsr_pkg::A_R2_LOW_HI)) r2_lohi_reg <= wr_data;
      if (wr_bank(wr_addr, tsr_pkg::A_BANK_HIGH_LO, 1'b1, bank2) ||
          wr_at(wr_addr, tsr_pkg::A_R2_HIGH_LO)) r2_hilo_reg <= wr_data;
      if (wr_bank(wr_addr, tsr_pkg::A_BANK_LOW_LO, 1'b1, bank2) ||
          wr_at(wr_addr, tsr_pkg::A_R2_LOW_LO)) r2_lolo_reg <= wr_data;
      if (wr_bank(wr_addr, tsr_pkg::A_BANK_OVT, 1'b1, bank2) ||
          wr_at(wr_addr, tsr_pkg::A_R2_OVT)) r2_ovt_reg <= wr_data;
    end
  end

  // Offsets; low bytes keep only the two fraction bits
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r1_ofs_hi_reg <= tsr_pkg::RST_ZERO;
      r1_ofs_lo_reg <= tsr_pkg::RST_ZERO;
      r2_ofs_hi_reg <= tsr_pkg::RST_ZERO;
      r2_ofs_lo_reg <= tsr_pkg::RST_ZERO;
    end else begin
      if (wr_bank(wr_addr, tsr_pkg::A_BANK_OFS_HI, 1'b0, bank2))
        r1_ofs_hi_reg <= wr_data;
      if (wr_bank(wr_addr, tsr_pkg::A_BANK_OFS_LO, 1'b0, bank2))
        r1_ofs_lo_reg <= wr_data & tsr_pkg::OFS_LO_MASK;
      if (wr_bank(wr_addr, tsr_pkg::A_BANK_OFS_HI, 1'b1, bank2) ||
          wr_at(wr_addr, tsr_pkg::A_R2_OFS_HI))
        r2_ofs_hi_reg <= wr_data;
      if (wr_bank(wr_addr, tsr_pkg::A_BANK_OFS_LO, 1'b1, bank2) ||
          wr_at(wr_addr, tsr_pkg::A_R2_OFS_LO))
        r2_ofs_lo_reg <= wr_data & tsr_pkg::OFS_LO_MASK;
    end
  end

  // Single conversion: write event only, nothing stored
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      single_conv_start <= 1'b0;
    end else begin
      single_conv_start <= wr_at(wr_addr, tsr_pkg::WA_SINGLE_CONV) && standby;
    end
  end

  // Offset applied to remote reading, quarter-degree units, saturating
  logic signed [tsr_pkg::OFS_W-1:0] ofs;
  logic signed [tsr_pkg::TEMP_W+1:0] sum;
  logic [tsr_pkg::TEMP_W-1:0] sat;
  logic [tsr_pkg::TEMP_W-1:0] adj_q_reg;

  // Fraction bits sit at the top of the low byte
  assign ofs = meas.chan2 ?
               {r2_ofs_hi_reg, r2_ofs_lo_reg[tsr_pkg::DW-1 -: tsr_pkg::FRAC_W]} :
               {r1_ofs_hi_reg, r1_ofs_lo_reg[tsr_pkg::DW-1 -: tsr_pkg::FRAC_W]};
  assign sum = $signed({2'b00, meas.raw}) + {{2{ofs[tsr_pkg::OFS_W-1]}}, ofs};
  // Clamp rather than wrap: a wrapped reading would trip the wrong limit
  assign sat = sum[tsr_pkg::TEMP_W+1] ? '0 :
               (sum[tsr_pkg::TEMP_W] ? '1 : sum[tsr_pkg::TEMP_W-1:0]);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      adj_q_reg <= '0;
      adj_valid <= 1'b0;
      adj_chan2 <= 1'b0;
    end else begin
      adj_valid <= meas_valid;
      if (meas_valid) begin
        adj_q_reg <= sat;
        adj_chan2 <= meas.chan2;
      end
    end
  end

  assign adj_temp_hi = adj_q_reg[tsr_pkg::TEMP_W-1:tsr_pkg::FRAC_W];
  assign adj_temp_lo = {adj_q_reg[tsr_pkg::FRAC_W-1:0], {(tsr_pkg::DW-tsr_pkg::FRAC_W){1'b0}}};

  // Stored values per remote channel for readback
  logic [7:0] r1_thi_reg, r1_tlo_reg, r2_thi_reg, r2_tlo_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r1_thi_reg <= tsr_pkg::RST_ZERO;
      r1_tlo_reg <= tsr_pkg::RST_ZERO;
      r2_thi_reg <= tsr_pkg::RST_ZERO;
      r2_tlo_reg <= tsr_pkg::RST_ZERO;
    end else if (adj_valid && adj_chan2) begin
      r2_thi_reg <= adj_temp_hi;
      r2_tlo_reg <= adj_temp_lo;
    end else if (adj_valid) begin
      r1_thi_reg <= adj_temp_hi;
      r1_tlo_reg <= adj_temp_lo;
    end
  end

  // Alarm count decode; unlisted codes fall back to one
  always_comb begin
    case (actl_reg[tsr_pkg::AC_CNT_MSB:tsr_pkg::AC_CNT_LSB])
      tsr_pkg::CNT_TWO: alarm_threshold = tsr_pkg::THR_TWO;
      tsr_pkg::CNT_THREE: alarm_threshold = tsr_pkg::THR_THREE;
      tsr_pkg::CNT_FOUR: alarm_threshold = tsr_pkg::THR_FOUR;
      default: alarm_threshold = tsr_pkg::THR_ONE;
    endcase
  end

  assign scl_timeout_en = actl_reg[tsr_pkg::AC_SCL_TO_BIT];
  assign sda_timeout_en = actl_reg[tsr_pkg::AC_SDA_TO_BIT];
  assign mask_local = actl_reg[tsr_pkg::AC_MASK_LOCAL_BIT];
  assign config_one = cfg1_reg;
  assign rate_sel = rate_reg;

  // Read decode; write-only and unmapped addresses read zero
  logic [7:0] rd_mux;

  always_comb begin
    if (rd_ptr_reg == tsr_pkg::RA_LOCAL_TEMP) rd_mux = local_temp;
    else if (rd_ptr_reg == tsr_pkg::RA_BANK_TEMP_HI) rd_mux = bank2 ? r2_thi_reg : r1_thi_reg;
    else if (rd_ptr_reg == tsr_pkg::RA_STATUS_ONE) rd_mux = status_one_in;
    else if (rd_ptr_reg == tsr_pkg::RA_CONFIG_ONE) rd_mux = cfg1_reg;
    else if (rd_ptr_reg == tsr_pkg::RA_RATE) rd_mux = rate_reg;
    else if (rd_ptr_reg == tsr_pkg::RA_LOCAL_HIGH) rd_mux = lhi_reg;
    else if (rd_ptr_reg == tsr_pkg::RA_LOCAL_LOW) rd_mux = llo_reg;
    else if (rd_ptr_reg == tsr_pkg::RA_BANK_HIGH_HI) rd_mux = bank2 ? r2_hihi_reg : r1_hihi_reg;
    else if (rd_ptr_reg == tsr_pkg::RA_BANK_LOW_HI) rd_mux = bank2 ? r2_lohi_reg : r1_lohi_reg;
    else if (rd_ptr_reg == tsr_pkg::RA_BANK_TEMP_LO) rd_mux = bank2 ? r2_tlo_reg : r1_tlo_reg;
    else if (rd_ptr_reg == tsr_pkg::A_BANK_OFS_HI) rd_mux = bank2 ? r2_ofs_hi_reg : r1_ofs_hi_reg;
    else if (rd_ptr_reg == tsr_pkg::A_BANK_OFS_LO) rd_mux = bank2 ? r2_ofs_lo_reg : r1_ofs_lo_reg;
    else if (rd_ptr_reg == tsr_pkg::A_BANK_HIGH_LO) rd_mux = bank2 ? r2_hilo_reg : r1_hilo_reg;
    else if (rd_ptr_reg == tsr_pkg::A_BANK_LOW_LO) rd_mux = bank2 ? r2_lolo_reg : r1_lolo_reg;
    else if (rd_ptr_reg == tsr_pkg::A_BANK_OVT) rd_mux = bank2 ? r2_ovt_reg : r1_ovt_reg;
    else if (rd_ptr_reg == tsr_pkg::A_LOCAL_OVT) rd_mux = ovt_l_reg;
    else if (rd_ptr_reg == tsr_pkg::A_OVT_HYST) rd_mux = hyst_reg;
    else if (rd_ptr_reg == tsr_pkg::A_ALARM_CTRL) rd_mux = actl_reg;
    else if (rd_ptr_reg == tsr_pkg::RA_STATUS_TWO) rd_mux = status_two_in;
    else if (rd_ptr_reg == tsr_pkg::A_CONFIG_TWO) rd_mux = cfg2_reg;
    else if (rd_ptr_reg == tsr_pkg::RA_R2_TEMP_HI) rd_mux = r2_thi_reg;
    else if (rd_ptr_reg == tsr_pkg::A_R2_HIGH_HI) rd_mux = r2_hihi_reg;
    else if (rd_ptr_reg == tsr_pkg::A_R2_LOW_HI) rd_mux = r2_lohi_reg;
    else if (rd_ptr_reg == tsr_pkg::RA_R2_TEMP_LO) rd_mux = r2_tlo_reg;
    else if (rd_ptr_reg == tsr_pkg::A_R2_OFS_HI) rd_mux = r2_ofs_hi_reg;
    else if (rd_ptr_reg == tsr_pkg::A_R2_OFS_LO) rd_mux = r2_ofs_lo_reg;
    else if (rd_ptr_reg == tsr_pkg::A_R2_HIGH_LO) rd_mux = r2_hilo_reg;
    else if (rd_ptr_reg == tsr_pkg::A_R2_LOW_LO) rd_mux = r2_lolo_reg;
    else if (rd_ptr_reg == tsr_pkg::A_R2_OVT) rd_mux = r2_ovt_reg;
    else if (rd_ptr_reg == tsr_pkg::RA_PART_ID) rd_mux = PART_ID;
    else if (rd_ptr_reg == tsr_pkg::RA_MAKER_ID) rd_mux = MAKER_ID;
    else rd_mux = tsr_pkg::RST_ZERO;
  end

  // Read byte registered in system domain; host samples it a few link clocks after rd_req
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_data <= tsr_pkg::RST_ZERO;
    end else begin
      rd_data <= rd_mux;
    end
  end

  // rd_req kept for the serial engine's timing; the byte is always current
  logic unused_rd_req;
  assign unused_rd_req = rd_req;
endmodule

// ### tb/tsr_regs_properties.sv
// Concurrent checks on the ports of the temperature monitor register bank
`timescale 1ns/1ps
module tsr_regs_properties (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic standby,
  input wire logic meas_valid,
  input wire tsr_pkg::tsr_meas_s meas,
  input wire logic single_conv_start,
  input wire logic [7:0] adj_temp_lo,
  input wire logic adj_valid,
  input wire logic adj_chan2,
  input wire logic [2:0] alarm_threshold,
  input wire logic scl_timeout_en,
  input wire logic sda_timeout_en,
  input wire logic mask_local,
  input wire logic [7:0] config_one,
  input wire logic [7:0] rate_sel
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_adj_after_meas: assert property (meas_valid |=> adj_valid)
    else $error("adjusted reading missing after measurement");
  a_adj_has_cause: assert property (adj_valid |-> $past(meas_valid))
    else $error("adjusted reading without measurement");
  a_adj_chan_kept: assert property (meas_valid |=> adj_chan2 == $past(meas.chan2))
    else $error("adjusted reading on wrong channel");
  a_adj_frac_clean: assert property (adj_valid |-> adj_temp_lo[5:0] == 6'h00)
    else $error("adjusted low byte has stray bits");
  a_conv_in_standby: assert property (single_conv_start |-> $past(standby))
    else $error("single conversion started outside standby");
  a_conv_one_pulse: assert property (single_conv_start |=> !single_conv_start [*8])
    else $error("single conversion start repeated");
  a_thr_in_range: assert property (alarm_threshold >= 3'h1 && alarm_threshold <= 3'h4)
    else $error("alarm count out of range");
  a_reset_values: assert property (disable iff (1'b0) !rst_n |=>
    rate_sel == 8'h07 && config_one == 8'h00 && alarm_threshold == 3'h1
    && !scl_timeout_en && !sda_timeout_en && !mask_local)
    else $error("control outputs not at reset values");
endmodule

bind tsr_regs tsr_regs_properties u_props (.clk, .rst_n, .standby, .meas_valid, .meas,
  .single_conv_start, .adj_temp_lo, .adj_valid, .adj_chan2, .alarm_threshold,
  .scl_timeout_en, .sda_timeout_en, .mask_local, .config_one, .rate_sel);

// ### tb/tsr_host_model.sv
// Host side model: serial engine byte events on the link clock
`timescale 1ns/1ps
module tsr_host_model (
  input wire logic link_clk,
  output logic wr_byte_valid,
  output tsr_pkg::tsr_wbyte_s wr_byte
);
  initial begin
    wr_byte_valid = 1'b0;
    wr_byte = '0;
  end
  task automatic send(input logic first, input logic [7:0] data);
    @(posedge link_clk);
    #1;
    wr_byte_valid = 1'b1;
    wr_byte = {first, data};
    @(posedge link_clk);
    #1;
    wr_byte_valid = 1'b0;
    // Idle data flips so a stale byte never reads as held
    wr_byte = ~wr_byte;
    // Crossing needs twelve link clocks between bytes
    repeat (11) @(posedge link_clk);
  endtask
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    send(1'b1, addr);
    send(1'b0, data);
  endtask
endmodule

// ### tb/tsr_regs_tb.sv
// Self-checking bench of the temperature monitor register bank
`timescale 1ns/1ps
module tsr_regs_tb;
  typedef struct packed {
    logic w;
    logic [7:0] wa;
    logic [7:0] wd;
    logic [7:0] ra;
    logic [7:0] ex;
  } tsr_row_s;
  logic clk, rst_n, link_clk, link_rst_n, standby, meas_valid, wr_byte_valid;
  tsr_pkg::tsr_wbyte_s wr_byte;
  tsr_pkg::tsr_meas_s meas;
  logic [7:0] rd_data, adj_temp_hi, adj_temp_lo, config_one, rate_sel;
  logic single_conv_start, adj_valid, adj_chan2, scl_timeout_en, sda_timeout_en, mask_local;
  logic [2:0] alarm_threshold;
  int n_fail = 0;
  int num_checks = 0;
  int n_conv = 0;
  logic [7:0] codes [5] = '{8'h00, 8'h02, 8'h06, 8'h0e, 8'h01};
  logic [2:0] thr [5] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h1};
  tsr_row_s rows [25] = '{
    '{1'b0, 8'h00, 8'h00, 8'h04, 8'h07}, '{1'b0, 8'h00, 8'h00, 8'h05, 8'h55},
    '{1'b0, 8'h00, 8'h00, 8'h07, 8'h55}, '{1'b0, 8'h00, 8'h00, 8'h11, 8'h00},
    '{1'b0, 8'h00, 8'h00, 8'h12, 8'h00}, '{1'b0, 8'h00, 8'h00, 8'h21, 8'h0a},
    '{1'b0, 8'h00, 8'h00, 8'h22, 8'h01}, '{1'b0, 8'h00, 8'h00, 8'h34, 8'h00},
    '{1'b0, 8'h00, 8'h00, 8'h39, 8'h55}, '{1'b0, 8'h00, 8'h00, 8'h3d, 8'h5a},
    '{1'b0, 8'h00, 8'h00, 8'h3e, 8'ha5}, '{1'b0, 8'h00, 8'h00, 8'h00, 8'h2a},
    '{1'b0, 8'h00, 8'h00, 8'h23, 8'h15}, '{1'b1, 8'h0b, 8'h12, 8'h05, 8'h12},
    '{1'b1, 8'h05, 8'h77, 8'h05, 8'h12}, '{1'b1, 8'h3e, 8'h33, 8'h3e, 8'ha5},
    '{1'b1, 8'h0f, 8'hff, 8'h0f, 8'h00}, '{1'b1, 8'h12, 8'hff, 8'h12, 8'hc0},
    '{1'b1, 8'h22, 8'hff, 8'h22, 8'hef}, '{1'b1, 8'h09, 8'h08, 8'h03, 8'h08},
    '{1'b1, 8'h11, 8'hfc, 8'h34, 8'hfc}, '{1'b1, 8'h0d, 8'h66, 8'h31, 8'h66},
    '{1'b1, 8'h09, 8'h00, 8'h12, 8'hc0}, '{1'b0, 8'h00, 8'h00, 8'h07, 8'h55},
    '{1'b1, 8'h0a, 8'h05, 8'h04, 8'h05}};

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    link_clk = 1'b0;
    #13;
    forever #40 link_clk = ~link_clk;
  end
  always @(posedge clk) if (single_conv_start === 1'b1) n_conv++;

  tsr_regs dut (.clk, .rst_n, .link_clk, .link_rst_n, .wr_byte_valid, .wr_byte,
    .rd_req(1'b0), .rd_data, .standby, .meas_valid, .meas, .local_temp(8'h2a),
    .status_one_in(8'h3c), .status_two_in(8'h15), .single_conv_start, .adj_temp_hi,
    .adj_temp_lo, .adj_valid, .adj_chan2, .alarm_threshold, .scl_timeout_en,
    .sda_timeout_en, .mask_local, .config_one, .rate_sel);
  tsr_host_model host (.link_clk, .wr_byte_valid, .wr_byte);

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp);
    host.send(1'b1, a);
    @(posedge clk);
    #1;
    chk(rd_data, exp);
  endtask
  task automatic msr(input logic c2, input logic [9:0] raw, input logic [7:0] hi, lo);
    @(posedge clk);
    #1;
    meas_valid = 1'b1;
    meas = {c2, raw};
    @(posedge clk);
    #1;
    meas_valid = 1'b0;
    chk({7'h00, adj_valid}, 8'h01);
    chk({7'h00, adj_chan2}, {7'h00, c2});
    chk(adj_temp_hi, hi);
    chk(adj_temp_lo, lo);
  endtask
  task automatic do_reset();
    rst_n = 1'b0;
    link_rst_n = 1'b0;
    repeat (8) @(posedge clk);
    #1;
    rst_n = 1'b1;
    link_rst_n = 1'b1;
    repeat (6) @(posedge clk);
  endtask
  task automatic finish_test();
    if (n_fail == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    n_fail++;
    finish_test();
  end
  initial begin
    standby = 1'b0;
    meas_valid = 1'b0;
    meas = '0;
    do_reset();
    msr(1'b1, 10'h3ff, 8'hff, 8'hc0);
    foreach (rows[i]) begin
      if (rows[i].w) begin
        host.write_reg(rows[i].wa, rows[i].wd);
      end
      chk_rd(rows[i].ra, rows[i].ex);
    end
    chk(rate_sel, 8'h05);
    chk(n_conv[7:0], 8'h00);
    foreach (codes[i]) begin
      host.write_reg(8'h22, codes[i]);
      chk({5'h00, alarm_threshold}, {5'h00, thr[i]});
    end
    host.write_reg(8'h22, 8'hc0);
    chk({5'h00, scl_timeout_en, sda_timeout_en, mask_local}, 8'h06);
    host.write_reg(8'h22, 8'h20);
    chk({5'h00, scl_timeout_en, sda_timeout_en, mask_local}, 8'h01);
    // Offsets now: first remote +3 quarters, second remote -16 quarters
    msr(1'b0, 10'd100, 8'h19, 8'hc0);
    msr(1'b1, 10'd100, 8'h15, 8'h00);
    chk_rd(8'h30, 8'h15);
    msr(1'b1, 10'd5, 8'h00, 8'h00);
    host.write_reg(8'h11, 8'h7f);
    msr(1'b0, 10'h3f0, 8'hff, 8'hc0);
    chk_rd(8'h01, 8'hff);
    chk_rd(8'h10, 8'hc0);
    host.write_reg(8'h09, 8'h08);
    chk(config_one, 8'h08);
    chk_rd(8'h01, 8'h00);
    chk_rd(8'h10, 8'h00);
    // Alarm outputs are not watched during the single conversion
    standby = 1'b1;
    host.write_reg(8'h0f, 8'h5a);
    chk(n_conv[7:0], 8'h01);
    standby = 1'b0;
    host.write_reg(8'h0f, 8'h5a);
    chk(n_conv[7:0], 8'h01);
    do_reset();
    chk_rd(8'h11, 8'h00);
    chk_rd(8'h35, 8'h00);
    chk_rd(8'h22, 8'h01);
    finish_test();
  end
endmodule
